/* File: hw/link_partner_next_page_regs.sv */
// Purpose: Management registers for the received next page word and control register one
// Assumes: AXI4-Lite slave, 32-bit data, one outstanding write and one read
// Notes:   16-bit registers sit in the low half of each word; upper bits read zero
//
// Operation
// - Bit 15 of the received page reads 1 when the partner wants to send more next pages.
// - Bit 14 reads 1 when the partner acknowledged our code word, else 0.
// - Bit 13 reads 1 for a message page and 0 for an unformatted page.
// - Bit 12 reports the partner's acknowledge2, 1 meaning it can comply with the message.
// - Bit 11 reports the partner's toggle flag, the inverse of the previous word's toggle.
// - Bits 10 to 0 carry the received code field, message code or unformatted data.
// - With autorun bit 8 of control register one set, a cable test starts after each link drop.
// - The received page register sits at index 0x8, resets to zero and is read-only.
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
`include "lpnp_defs.svh"

module link_partner_next_page_regs
  import lpnp_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output var  logic        s_axi_awready_o,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output var  logic        s_axi_wready_o,
  // AXI4-Lite write response
  output var  logic [1:0]  s_axi_bresp_o,
  output var  logic        s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output var  logic        s_axi_arready_o,
  // AXI4-Lite read data
  output var  logic [31:0] s_axi_rdata_o,
  output var  logic [1:0]  s_axi_rresp_o,
  output var  logic        s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  // Link side
  input  wire np_page_type page_i,
  input  wire logic        page_valid_i,
  input  wire logic        link_up_i,
  output var  logic        cable_test_start_o
);

  localparam int IDX_W = ADDR_W - 2;

  // Index must reach the highest register
  generate
    if (ADDR_W < 6 || ADDR_W > 32) begin : g_bad_addr_w
      $error("ADDR_W must lie between 6 and 32");
    end
  endgenerate

  logic              rst_meta;
  logic              rst_n;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0]       wr_data;
  logic [3:0]        wr_strb;
  logic              do_write;
  logic [IDX_W-1:0]  wr_idx;
  logic [IDX_W-1:0]  rd_idx;
  logic              cable_echo_autorun;
  logic              link_up_q;
  logic              link_drop;
  np_page_type       link_partner_next_page;
  logic [15:0]       next_page_word;
  logic [15:0]       ctrl_one_word;
  logic [31:0]       next_rdata;
  logic [1:0]        next_rresp;

  // Reset release through two flip-flops; assertion stays asynchronous
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // Held received page; only the link side ever changes it
  np_page_store u_page_store (
    .core_clk_i   (core_clk_i),
    .rst_n_i      (rst_n),
    .page_valid_i (page_valid_i),
    .page_i       (page_i),
    .page_o       (link_partner_next_page)
  );

  // Register images as seen by software
  always_comb begin
    next_page_word = 16'h0000;
    next_page_word[`LPNP_BIT_NEXT_PAGE] = link_partner_next_page.next_page;
    next_page_word[`LPNP_BIT_ACK]       = link_partner_next_page.ack;
    next_page_word[`LPNP_BIT_MSG_PAGE]  = link_partner_next_page.message_page;
    next_page_word[`LPNP_BIT_ACK2]      = link_partner_next_page.ack2;
    next_page_word[`LPNP_BIT_TOGGLE]    = link_partner_next_page.toggle;
    next_page_word[`LPNP_CODE_MSB:`LPNP_CODE_LSB] = link_partner_next_page.code;
    ctrl_one_word = 16'h0000;
    ctrl_one_word[`LPNP_BIT_AUTORUN] = cable_echo_autorun;
  end

  // Address and data may arrive in either order; both held until the write
  assign do_write = !s_axi_awready_o && !s_axi_wready_o && !s_axi_bvalid_o;
  assign wr_idx   = wr_addr[ADDR_W-1:2];

  // Write address channel; ready drops while an address is held
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready_o <= 1'b1;
      wr_addr         <= '0;
    end else if (s_axi_awvalid_i && s_axi_awready_o) begin
      s_axi_awready_o <= 1'b0;
      wr_addr         <= s_axi_awaddr_i;
    end else if (do_write) begin
      s_axi_awready_o <= 1'b1;
    end
  end

  // Write data channel, same holding scheme
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_wready_o <= 1'b1;
      wr_data        <= 32'h0000_0000;
      wr_strb        <= 4'h0;
    end else if (s_axi_wvalid_i && s_axi_wready_o) begin
      s_axi_wready_o <= 1'b0;
      wr_data        <= s_axi_wdata_i;
      wr_strb        <= s_axi_wstrb_i;
    end else if (do_write) begin
      s_axi_wready_o <= 1'b1;
    end
  end

  // Write response; the received page index is mapped but takes no write
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= `LPNP_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid_o <= 1'b1;
      if (wr_idx == IDX_W'(`LPNP_IDX_NEXT_PAGE) || wr_idx == IDX_W'(`LPNP_IDX_CTRL_ONE)) begin
        s_axi_bresp_o <= `LPNP_RESP_OKAY;
      end else begin
        s_axi_bresp_o <= `LPNP_RESP_SLVERR;
      end
    end else if (s_axi_bvalid_o && s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  // Autorun control; bit 8 sits in byte lane 1
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cable_echo_autorun <= 1'(`LPNP_CTRL_ONE_RST >> `LPNP_BIT_AUTORUN);
    end else if (do_write && wr_idx == IDX_W'(`LPNP_IDX_CTRL_ONE) && wr_strb[1]) begin
      cable_echo_autorun <= wr_data[`LPNP_BIT_AUTORUN];
    end
  end

  // Read decode; unmapped words answer zero with an error
  assign rd_idx = s_axi_araddr_i[ADDR_W-1:2];

  always_comb begin
    next_rdata = 32'h0000_0000;
    next_rresp = `LPNP_RESP_OKAY;
    if (rd_idx == IDX_W'(`LPNP_IDX_NEXT_PAGE)) begin
      next_rdata = {16'h0000, next_page_word};
    end else if (rd_idx == IDX_W'(`LPNP_IDX_CTRL_ONE)) begin
      next_rdata = {16'h0000, ctrl_one_word};
    end else begin
      next_rresp = `LPNP_RESP_SLVERR;
    end
  end

  // Read channel; one read in flight, data captured at the address edge
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= 32'h0000_0000;
      s_axi_rresp_o   <= `LPNP_RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b1;
      s_axi_rdata_o   <= next_rdata;
      s_axi_rresp_o   <= next_rresp;
    end else if (s_axi_rvalid_o && s_axi_rready_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o  <= 1'b0;
    end
  end

  // Link drop edge; reset value 0 so no start fires after reset
  assign link_drop = link_up_q && !link_up_i;

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      link_up_q <= 1'b0;
    end else begin
      link_up_q <= link_up_i;
    end
  end

  // One-cycle start of the cable test after each drop, only when enabled
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cable_test_start_o <= 1'b0;
    end else begin
      cable_test_start_o <= link_drop && cable_echo_autorun;
    end
  end

endmodule // link_partner_next_page_regs
`default_nettype wire

/* File: hw/lpnp_defs.svh */
// Purpose: Offsets, field positions, reset values for the next page register block
// Assumes: Included by bare name; definitions only
// Notes:   Printed offsets are word indices; byte address is four times the index
`ifndef LPNP_DEFS_SVH
`define LPNP_DEFS_SVH

// Word indices of the registers
`define LPNP_IDX_NEXT_PAGE   8'h08
`define LPNP_IDX_CTRL_ONE    8'h09

// Reset values
`define LPNP_NEXT_PAGE_RST   16'h0000
`define LPNP_CTRL_ONE_RST    16'h0000

// Field positions in the received next page word
`define LPNP_BIT_NEXT_PAGE   15
`define LPNP_BIT_ACK         14
`define LPNP_BIT_MSG_PAGE    13
`define LPNP_BIT_ACK2        12
`define LPNP_BIT_TOGGLE      11
`define LPNP_CODE_MSB        10
`define LPNP_CODE_LSB        0

// Field position of the autorun control in control register one
`define LPNP_BIT_AUTORUN     8

// AXI response codes
`define LPNP_RESP_OKAY       2'h0
`define LPNP_RESP_SLVERR     2'h2

`endif

/* File: hw/lpnp_pkg.sv */
// Purpose: Types shared by the next page register block
// Assumes: Field order matches the register layout, bit 15 first
// Notes:   Constants live in lpnp_defs.svh
package lpnp_pkg;

  // One received next page code word
  typedef struct packed {
    logic        next_page;
    logic        ack;
    logic        message_page;
    logic        ack2;
    logic        toggle;
    logic [10:0] code;
  } np_page_type;

  // Write-side handshake signals of the register bus
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
  } axil_wr_resp_type;

  // Read-side handshake signals of the register bus
  typedef struct packed {
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } axil_rd_resp_type;

endpackage

/* File: hw/np_page_store.sv */
// Purpose: Holds the latest next page code word accepted from the link partner
// Assumes: page_valid_i is a one-cycle strobe in the management clock domain
// Notes:   Reset value is all zeros; the word is never written by software
`timescale 1ns/1ns
`default_nettype none
`include "lpnp_defs.svh"

module np_page_store
  import lpnp_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        page_valid_i,
  input  wire np_page_type page_i,
  output var  np_page_type page_o
);

  // Latest accepted page replaces the held one
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      page_o <= np_page_type'(`LPNP_NEXT_PAGE_RST);
    end else if (page_valid_i) begin
      page_o <= page_i;
    end
  end

endmodule // np_page_store
`default_nettype wire

/* File: verification/lpnp_checker.sv */
// Purpose: Port assertions for the next page register block
// Assumes: Byte addresses 0x20 and 0x24, read answer one edge after take
// Notes:   Bound into the register block after the module
`timescale 1ns/1ns
`default_nettype none
module lpnp_checker
  import lpnp_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic              core_clk_i,
  input wire logic              rst_n_i,
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic              s_axi_arvalid_i,
  input wire logic              s_axi_arready_o,
  input wire logic [31:0]       s_axi_rdata_o,
  input wire logic [1:0]        s_axi_rresp_o,
  input wire logic              s_axi_rvalid_o,
  input wire logic              s_axi_rready_i,
  input wire np_page_type       page_i,
  input wire logic              page_valid_i,
  input wire logic              link_up_i,
  input wire logic              cable_test_start_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  np_page_type held;
  // Shadow of the newest word, so reads can be judged without the bench
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) held <= '0;
    else if (page_valid_i) held <= page_i;
  end
  sequence s_ar_take; s_axi_arvalid_i && s_axi_arready_o; endsequence
  sequence s_np_read; s_ar_take ##0 (s_axi_araddr_i == 'h20); endsequence
  property p_rd_lat; s_ar_take |=> s_axi_rvalid_o && !s_axi_arready_o; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_rd_hold; s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data dropped");
  property p_upper; s_axi_rvalid_o |-> s_axi_rdata_o[31:16] == 16'h0000; endproperty
  a_upper: assert property (p_upper) else $error("upper half not zero");
  property p_page; s_np_read |=> s_axi_rdata_o == {16'h0000, $past(held)}; endproperty
  a_page: assert property (p_page) else $error("page word wrong");
  property p_flags; s_np_read |=> s_axi_rdata_o[15:11] == $past(held[15:11]); endproperty
  a_flags: assert property (p_flags) else $error("page flags wrong");
  // Byte addresses 0x25 to 0x27 still fall on control register one
  property p_unmap; s_ar_take ##0 (s_axi_araddr_i > 'h27) |=> s_axi_rresp_o == 2'h2; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not refused");
  // Start follows a high-then-low link sample one edge later
  property p_drop; cable_test_start_o |-> $past(link_up_i, 2) && !$past(link_up_i); endproperty
  a_drop: assert property (p_drop) else $error("test start without drop");
  property p_pulse; cable_test_start_o |=> !cable_test_start_o [*2]; endproperty
  a_pulse: assert property (p_pulse) else $error("test start too long");
endmodule // lpnp_checker
bind link_partner_next_page_regs lpnp_checker #(.ADDR_W(ADDR_W)) u_chk (.*);
`default_nettype wire

/* File: verification/link_partner_model.sv */
// Purpose: Remote link partner offering next page words
// Assumes: Called from the bench through its tasks
// Notes:   Idle page lines show the inverse of the last word
`timescale 1ns/1ns
`default_nettype none
module link_partner_model
  import lpnp_pkg::*;
(
  input  wire logic        core_clk_i,
  output var  np_page_type page_o,
  output var  logic        valid_o,
  output var  logic        link_o
);
  logic tgl = 1'b0;
  // Quiet partner until told otherwise
  initial begin
    page_o = '0;
    valid_o = 1'b0;
    link_o = 1'b0;
  end
  // Toggle flips word by word, as a real partner would
  task automatic send(input logic [31:0] w, output logic [15:0] sent);
    np_page_type p;
    p = w[15:0];
    p.toggle = tgl;
    @(posedge core_clk_i);
    page_o <= p;
    valid_o <= 1'b1;
    tgl <= ~tgl;
    @(posedge core_clk_i);
    page_o <= ~p;
    valid_o <= 1'b0;
    sent = p;
  endtask
  task automatic set_link(input logic up);
    @(posedge core_clk_i);
    link_o <= up;
  endtask
endmodule // link_partner_model
`default_nettype wire

/* File: verification/tb_top.sv */
// Purpose: Self-checking bench for the next page register block
// Assumes: Byte addresses 0x20 and 0x24, 8-bit bus address
// Notes:   Expected values come from an integer model of the registers
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import lpnp_pkg::*;
;
  logic        core_clk_i, rst_n_i, page_valid_i, link_up_i, s_axi_awvalid_i;
  logic        s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i;
  logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
  logic        s_axi_rvalid_o, cable_test_start_o;
  logic [7:0]  s_axi_awaddr_i, s_axi_araddr_i;
  logic [3:0]  s_axi_wstrb_i;
  logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, resp;
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o, rd;
  logic [15:0] sent;
  np_page_type page_i;
  int          fail_count = 0, samples_checked = 0, pulses = 0, mdl_page = 0, mdl_ctrl, p0;
  int unsigned seed = 77401;
  link_partner_next_page_regs uut (.*);
  link_partner_model lp (.core_clk_i, .page_o(page_i), .valid_o(page_valid_i), .link_o(link_up_i));
  initial begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end
  // Pulses seen mid-cycle, clear of the launching edge
  always @(negedge core_clk_i) pulses += (cable_test_start_o === 1'b1);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      $display("Error t=%0t got=%h exp=%h", $time, g, e);
      fail_count++;
    end
  endtask
  // Address and data offered together, each dropped at its own take
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic ta, tw, ka, kw;
    ka = 1'b0;
    kw = 1'b0;
    @(posedge core_clk_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_wstrb_i <= s;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    do begin
      @(negedge core_clk_i);
      ta = s_axi_awvalid_i & s_axi_awready_o;
      tw = s_axi_wvalid_i & s_axi_wready_o;
      @(posedge core_clk_i);
      if (ta) s_axi_awvalid_i <= 1'b0;
      if (tw) s_axi_wvalid_i <= 1'b0;
      ka |= ta;
      kw |= tw;
    end while (!(ka && kw));
    do @(negedge core_clk_i); while (s_axi_bvalid_o !== 1'b1);
    @(posedge core_clk_i);
    s_axi_bready_i <= 1'b1;
    @(negedge core_clk_i);
    resp = s_axi_bresp_o;
    @(posedge core_clk_i);
    s_axi_bready_i <= 1'b0;
  endtask
  // Ready raised late on purpose, so the slave must hold its answer
  task automatic axi_rd(input logic [7:0] a);
    @(posedge core_clk_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    do @(negedge core_clk_i); while (s_axi_arready_o !== 1'b1);
    @(posedge core_clk_i);
    s_axi_arvalid_i <= 1'b0;
    do @(negedge core_clk_i); while (s_axi_rvalid_o !== 1'b1);
    @(posedge core_clk_i);
    s_axi_rready_i <= 1'b1;
    @(negedge core_clk_i);
    rd = s_axi_rdata_o;
    resp = s_axi_rresp_o;
    @(posedge core_clk_i);
    s_axi_rready_i <= 1'b0;
  endtask
  task automatic complete_run();
    $display("Counts checked=%0d failed=%0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Watchdog, far beyond the 130 or so cycles the tests need
  initial begin
    repeat (4000) @(posedge core_clk_i);
    fail_count++;
    complete_run();
  end
  initial begin
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i} = '0;
    {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i, s_axi_wstrb_i} = '0;
    rst_n_i = 1'b0;
    repeat (10) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    axi_rd(8'h20);
    chk(rd, 32'h0);
    axi_rd(8'h24);
    chk(rd, 32'h0);
    $display("Test reset values done");
    // Odd rounds send two words back to back; only the newest may show
    for (int i = 0; i < 6; i++) begin
      lp.send(rnd(), sent);
      if (i[0]) lp.send(rnd(), sent);
      mdl_page = sent;
      axi_rd(8'h20);
      chk(rd, mdl_page);
    end
    $display("Test received pages done");
    axi_wr(8'h20, rnd(), 4'hF);
    chk(resp, 32'h0);
    axi_rd(8'h20);
    chk(rd, mdl_page);
    $display("Test read-only page done");
    // Autorun on, then off; a write missing byte one must not change it
    for (int k = 1; k >= 0; k--) begin
      mdl_ctrl = k << 8;
      axi_wr(8'h24, mdl_ctrl, 4'h2);
      axi_wr(8'h24, ~mdl_ctrl, 4'h1);
      axi_rd(8'h24);
      chk(rd, mdl_ctrl);
      // Counter belongs to the sampler; only its growth is judged
      p0 = pulses;
      lp.set_link(1'b1);
      repeat (3) @(posedge core_clk_i);
      lp.set_link(1'b0);
      repeat (4) @(posedge core_clk_i);
      chk(pulses - p0, k);
    end
    $display("Test cable autorun done");
    axi_wr(8'h30, rnd(), 4'hF);
    chk(resp, 32'h2);
    axi_rd(8'h30);
    chk(rd, 32'h0);
    chk(resp, 32'h2);
    $display("Test unmapped access done");
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
